// [logic/ssp_pkg.sv]
// Shared constants and types of the stereo converter serial port.
package ssp_pkg;

  // ---------------------------------------------------------------
  // Sample format
  // ---------------------------------------------------------------
  localparam int SMP_W = 24;
  localparam int FIFO_DEPTH = 4;
  localparam int HPF_SHIFT = 13;
  localparam int HPF_FRAC = 16;

  // ---------------------------------------------------------------
  // Start-up frame counts
  // ---------------------------------------------------------------
  localparam int CAL_FR_NS = 8704;
  localparam int CAL_FR_DS = 17408;
  localparam int VALID_FR_NS = 8960;
  localparam int VALID_FR_DS = 17920;
  localparam int FCNT_W = 15;
  localparam logic [14:0] SLAVE_EXTRA_FR = 15'h0001;

  // ---------------------------------------------------------------
  // Clock relations, in system clock cycles and bit periods
  // ---------------------------------------------------------------
  localparam logic [9:0] FRAME_MCLK_NS = 10'h100;
  localparam logic [9:0] FRAME_MCLK_DS = 10'h080;
  localparam logic [9:0] PHASE_TOL = 10'h004;
  localparam logic [6:0] HALF_BITS_NS = 7'h40;
  localparam logic [6:0] HALF_BITS_DS = 7'h20;
  localparam logic [2:0] LOAD_GUARD = 3'h3;

  typedef struct packed {
    logic signed [23:0] left;
    logic signed [23:0] right;
  } ssp_pair_s;

  typedef struct packed {
    logic dbl;
    logic master;
    logic i2s;
    logic cal_src;
    logic hpf_en;
  } ssp_mode_s;

  typedef struct packed {
    logic bclk;
    logic frame_clock;
  } ssp_clk_s;

  typedef struct packed {
    logic signed [23:0] x1;
    logic signed [39:0] y;
  } ssp_hpf_s;

  typedef enum logic [2:0] {
    ST_CAL = 3'h1,
    ST_MUTE = 3'h2,
    ST_RUN = 3'h4
  } ssp_phase_e;

endpackage

// [logic/ssp_serial_port.sv]
// Sample FIFO and serial output port of the stereo converter.
// Summary of operation
// - Frame phase loss restarts calibration automatically (checked in slave mode only).
// - Two select pins choose one of four formats.
// - Samples sent MSB first, two's complement.
// - Reset low holds digital section down.
// - Reset release starts offset calibration.
// - Store per-channel offset, subtract it afterwards.
// - Source select picks inputs or common voltage.
// - Busy output high throughout calibration.
// - DC-blocking high-pass, 1Hz at 48kHz.
// - Busy ends after 8704/17408 frames, slave +1.
// - Data valid after 8960/17920 frames, slave +1.

// -----------------------------------------------------------------
// Sample FIFO
// -----------------------------------------------------------------
module ssp_fifo #(
  parameter int W = 48,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic rdy;
  } ssp_fifo_state_s;

  ssp_fifo_state_s q, d;

  always_comb begin
    d = q;
    if (in_valid && q.rdy) begin
      d.mem[q.wp[AW-1:0]] = in_data;
      d.wp = q.wp + 1'b1;
    end
    if (out_ready && (q.wp != q.rp)) begin
      d.rp = q.rp + 1'b1;
    end
    d.rdy = (d.wp - d.rp) != (AW+1)'(DEPTH);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.rdy <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign in_ready = q.rdy;
  assign out_valid = q.wp != q.rp;
  assign out_data = q.mem[q.rp[AW-1:0]];
endmodule

// -----------------------------------------------------------------
// Serial port top
// -----------------------------------------------------------------
module ssp_serial_port import ssp_pkg::*; #(
  parameter int CAL_FRAMES_NS = CAL_FR_NS,
  parameter int CAL_FRAMES_DS = CAL_FR_DS,
  parameter int VALID_FRAMES_NS = VALID_FR_NS,
  parameter int VALID_FRAMES_DS = VALID_FR_DS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic double_speed_sel,
  input wire logic format_sel_master,
  input wire logic format_sel_i2s,
  input wire logic cal_source_sel,
  input wire logic highpass_enable,
  input wire ssp_pair_s sample_data,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire ssp_pair_s common_voltage_pin_sample,
  input wire logic bit_clock_in,
  output logic bit_clock_out,
  output logic bit_clock_oe_n,
  input wire logic frame_clock_in,
  output logic frame_clock_out,
  output logic frame_clock_oe_n,
  output logic frame_sync_out,
  output logic frame_sync_oe_n,
  output logic serial_out,
  output logic cal_busy
);

  typedef struct packed {
    ssp_mode_s mode_m;
    ssp_mode_s mode;
    ssp_clk_s pin_m;
    ssp_clk_s pin;
    ssp_clk_s pin_prev;
    logic m_bclk;
    logic m_frame_clock;
    logic m_frame_sync;
    logic [6:0] m_bit;
    logic [2:0] guard;
    logic [24:0] shreg;
    logic sout;
    logic busy;
    logic oe_n;
    ssp_phase_e phase;
    logic [14:0] fcnt;
    logic [9:0] pcnt;
    logic armed;
    logic [1:0] settle;
    ssp_pair_s offs;
    ssp_hpf_s hl;
    ssp_hpf_s hr;
    logic signed [23:0] right_word;
  } ssp_state_s;

  ssp_state_s q, d;
  logic fifo_valid;
  logic fifo_pop;
  logic [47:0] fifo_data;

  function automatic logic signed [23:0] sat24(input logic signed [39:0] v);
    if (v > 40'sh00007FFFFF) begin
      return 24'sh7FFFFF;
    end else if (v < 40'shFFFF800000) begin
      return 24'sh800000;
    end
    return v[23:0];
  endfunction

  function automatic ssp_hpf_s hpf_step(input logic signed [23:0] x, input ssp_hpf_s s);
    ssp_hpf_s r;
    r.x1 = x;
    r.y = s.y + (40'(x) <<< HPF_FRAC) - (40'(s.x1) <<< HPF_FRAC) - (s.y >>> HPF_SHIFT);
    return r;
  endfunction

  ssp_fifo #(
    .W(48),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data(sample_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  logic fall, edge_ev, lvl, is_left;
  logic [6:0] half_bits;
  logic [9:0] exp_period;
  logic [14:0] cal_tgt, val_tgt;
  ssp_pair_s raw, cor;
  logic signed [23:0] wl, wr;

  always_comb begin
    d = q;
    fall = 1'b0;
    edge_ev = 1'b0;
    lvl = 1'b0;
    is_left = 1'b0;
    fifo_pop = 1'b0;
    raw = ssp_pair_s'(fifo_data);
    cor = '0;
    wl = '0;
    wr = '0;
    d.mode_m = '{double_speed_sel, format_sel_master, format_sel_i2s,
                 cal_source_sel, highpass_enable};
    d.mode = q.mode_m;
    d.pin_m = '{bit_clock_in, frame_clock_in};
    d.pin = q.pin_m;
    d.pin_prev = q.pin;
    // Pin edges count only once the synchroniser holds real samples.
    d.settle = (q.settle == 2'h3) ? q.settle : q.settle + 2'h1;
    d.oe_n = ~q.mode.master;
    half_bits = q.mode.dbl ? HALF_BITS_DS : HALF_BITS_NS;
    exp_period = q.mode.dbl ? FRAME_MCLK_DS : FRAME_MCLK_NS;
    cal_tgt = q.mode.dbl ? 15'(CAL_FRAMES_DS) : 15'(CAL_FRAMES_NS);
    val_tgt = q.mode.dbl ? 15'(VALID_FRAMES_DS) : 15'(VALID_FRAMES_NS);
    if (!q.mode.master) begin
      cal_tgt = cal_tgt + SLAVE_EXTRA_FR;
      val_tgt = val_tgt + SLAVE_EXTRA_FR;
    end
    // Bit and frame events come from the own divider or the host pins.
    if (q.mode.master) begin
      d.m_bclk = ~q.m_bclk;
      if (q.m_bclk) begin
        fall = 1'b1;
        if (q.m_bit == half_bits - 7'h01) begin
          d.m_bit = '0;
          d.m_frame_clock = ~q.m_frame_clock;
          edge_ev = 1'b1;
          lvl = ~q.m_frame_clock;
        end else begin
          d.m_bit = q.m_bit + 7'h01;
        end
        d.m_frame_sync = (d.m_bit != 7'h00) && (d.m_bit <= (half_bits >> 1));
      end
    end else begin
      fall = q.pin_prev.bclk && !q.pin.bclk && (q.guard == 3'h0) && (q.settle == 2'h3);
      edge_ev = (q.pin_prev.frame_clock != q.pin.frame_clock) && (q.settle == 2'h3);
      lvl = q.pin.frame_clock;
      d.m_bclk = 1'b0;
      d.m_frame_clock = 1'b0;
      d.m_frame_sync = 1'b0;
      d.m_bit = '0;
    end
    if (q.guard != 3'h0) begin
      d.guard = q.guard - 3'h1;
    end
    // Frame period watch: a lost lock restarts calibration.
    d.pcnt = (q.pcnt == 10'h3FF) ? q.pcnt : q.pcnt + 10'h001;
    if (edge_ev && lvl) begin
      d.pcnt = 10'h001;
      d.armed = 1'b1;
      d.fcnt = (q.fcnt == 15'h7FFF) ? q.fcnt : q.fcnt + 15'h0001;
      if (!q.mode.master && q.armed &&
          ((q.pcnt + PHASE_TOL < exp_period) || (q.pcnt > exp_period + PHASE_TOL))) begin
        d.fcnt = '0;
      end
    end
    // Start-up sequence: calibrate, then mute, then run.
    case (q.phase)
      ST_CAL: begin
        if (d.fcnt >= cal_tgt) begin
          d.phase = ST_MUTE;
        end
      end
      ST_MUTE: begin
        if (d.fcnt == '0) begin
          d.phase = ST_CAL;
        end else if (d.fcnt >= val_tgt) begin
          d.phase = ST_RUN;
        end
      end
      ST_RUN: begin
        if (d.fcnt == '0) begin
          d.phase = ST_CAL;
        end
      end
      default: begin
        d.phase = ST_CAL;
      end
    endcase
    d.busy = d.phase == ST_CAL;
    // Word loading at each frame edge, which wins over a bit fall at that edge; shifting at the other bit falls.
    if (edge_ev) begin
      is_left = lvl == ~q.mode.i2s;
      if (is_left) begin
        fifo_pop = fifo_valid;
        if (fifo_valid) begin
          cor.left = sat24(40'(raw.left) - 40'(q.offs.left));
          cor.right = sat24(40'(raw.right) - 40'(q.offs.right));
          if (q.phase == ST_CAL) begin
            d.offs = q.mode.cal_src ? raw : common_voltage_pin_sample;
          end else if (q.mode.hpf_en) begin
            d.hl = hpf_step(cor.left, q.hl);
            d.hr = hpf_step(cor.right, q.hr);
            wl = sat24(d.hl.y >>> HPF_FRAC);
            wr = sat24(d.hr.y >>> HPF_FRAC);
          end else begin
            wl = cor.left;
            wr = cor.right;
          end
        end
        if (d.phase != ST_RUN) begin
          wr = '0;
        end
        d.right_word = wr;
      end else begin
        wl = q.right_word;
      end
      if (d.phase != ST_RUN) begin
        wl = '0;
      end
      d.shreg = q.mode.i2s ? {1'b0, wl} : {wl, 1'b0};
      d.guard = q.mode.master ? 3'h0 : LOAD_GUARD;
    end else if (fall) begin
      d.shreg = {q.shreg[23:0], 1'b0};
    end
    d.sout = d.shreg[24];
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.phase <= ST_CAL;
      q.busy <= 1'b1;
      q.oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign bit_clock_out = q.m_bclk;
  assign frame_clock_out = q.m_frame_clock;
  assign frame_sync_out = q.m_frame_sync;
  assign bit_clock_oe_n = q.oe_n;
  assign frame_clock_oe_n = q.oe_n;
  assign frame_sync_oe_n = q.oe_n;
  assign serial_out = q.sout;
  assign cal_busy = q.busy;
endmodule

// [bench/ssp_monitor.sv]
// Checker bound to the serial port top.
module ssp_monitor import ssp_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic double_speed_sel,
  input wire logic format_sel_master,
  input wire logic bit_clock_out,
  input wire logic bit_clock_oe_n,
  input wire logic frame_clock_out,
  input wire logic frame_clock_oe_n,
  input wire logic frame_sync_out,
  input wire logic frame_sync_oe_n,
  input wire logic serial_out,
  input wire logic cal_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_busy_at_release: assert property ($rose(rst_n) |-> cal_busy)
    else $error("busy low at release");
  a_slave_oe_off: assert property (!format_sel_master [*4] |->
    bit_clock_oe_n && frame_clock_oe_n && frame_sync_oe_n)
    else $error("slave drives clocks");
  a_master_oe_on: assert property (format_sel_master [*4] |->
    !bit_clock_oe_n && !frame_clock_oe_n && !frame_sync_oe_n)
    else $error("master not driving");
  a_bclk_toggles: assert property (!bit_clock_oe_n [*3] |->
    bit_clock_out != $past(bit_clock_out))
    else $error("bit clock stalled");
  a_frame_on_fall: assert property (!frame_clock_oe_n && !$past(frame_clock_oe_n)
    && $changed(frame_clock_out) |-> $fell(bit_clock_out))
    else $error("frame edge off fall");
  a_frame_period: assert property (!frame_clock_oe_n && !double_speed_sel
    && $rose(frame_clock_out) |-> ##256 $rose(frame_clock_out))
    else $error("frame period wrong");
  a_sync_after_edge: assert property (!frame_clock_oe_n && !$past(frame_clock_oe_n)
    && $changed(frame_clock_out) |-> !frame_sync_out ##2 frame_sync_out)
    else $error("frame sync misplaced");
  a_mute_in_cal: assert property (cal_busy [*3] |-> !serial_out)
    else $error("data during calibration");
  c_busy_end: cover property ($fell(cal_busy));
  c_busy_again: cover property ($rose(cal_busy));
  c_sync_rise: cover property (!frame_clock_oe_n && $rose(frame_sync_out));
endmodule

bind ssp_serial_port ssp_monitor mon (.clk_sys, .rst_n, .double_speed_sel,
  .format_sel_master, .bit_clock_out, .bit_clock_oe_n, .frame_clock_out,
  .frame_clock_oe_n, .frame_sync_out, .frame_sync_oe_n, .serial_out, .cal_busy);

// [bench/ssp_host_model.sv]
// Host model that makes the slave clocks and captures 16 bits per half frame.
module ssp_host_model (
  input wire logic en,
  input wire logic stretch,
  input wire logic serial_out,
  output logic bclk,
  output logic fclk,
  output logic [15:0] hi_w,
  output logic [15:0] lo_w
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] sh;
  int n;
  // Half frame is 16 bit periods of 80 ns, 256 system clocks a frame.
  initial begin
    bclk = 0;
    fclk = 0;
    sh = 0;
    n = 0;
    hi_w = 0;
    lo_w = 0;
    #3;
    forever begin
      if (!en) begin
        bclk = 0;
        #10;
      end else begin
        #40 bclk = 1;
        #40;
        sh = {sh[14:0], serial_out};
        bclk = 0;
        n++;
        if (n >= (stretch ? 18 : 16)) begin
          n = 0;
          if (fclk) hi_w = sh;
          else lo_w = sh;
          fclk = ~fclk;
        end
      end
    end
  end
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the serial port.
module tb_top import ssp_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst_n, dbl, mst, i2s, zsrc, hpf, valid, stretch, en, bclk, fclk;
  logic sready, bclk_o, bclk_oe, fclk_o, fclk_oe, fs_o, fs_oe, sdo, busy;
  logic [15:0] hi_w, lo_w;
  ssp_pair_s data, common_voltage_pin;
  int bad_count, compares, n, k;
  ssp_serial_port #(.CAL_FRAMES_NS(8), .CAL_FRAMES_DS(16), .VALID_FRAMES_NS(12),
    .VALID_FRAMES_DS(20)) uut (.clk_sys, .rst_n, .double_speed_sel(dbl),
    .format_sel_master(mst), .format_sel_i2s(i2s), .cal_source_sel(zsrc),
    .highpass_enable(hpf), .sample_data(data), .sample_valid(valid),
    .sample_ready(sready), .common_voltage_pin_sample(common_voltage_pin), .bit_clock_in(bclk),
    .bit_clock_out(bclk_o), .bit_clock_oe_n(bclk_oe), .frame_clock_in(fclk),
    .frame_clock_out(fclk_o), .frame_clock_oe_n(fclk_oe), .frame_sync_out(fs_o),
    .frame_sync_oe_n(fs_oe), .serial_out(sdo), .cal_busy(busy));
  ssp_host_model host (.en, .stretch, .serial_out(sdo), .bclk, .fclk, .hi_w, .lo_w);
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic start(input logic m, d, s, z, h);
    @(negedge clk_sys);
    rst_n = 0;
    {mst, dbl, i2s, zsrc, hpf, en} = {m, d, s, z, h, !m};
    repeat (20) @(negedge clk_sys);
    chk("busy in reset", 16'h0001, {15'h0, busy});
    chk("oe in reset", 16'h0001, {15'h0, fclk_oe});
    chk("ready in reset", 16'h0001, {15'h0, sready});
    rst_n = 1;
  endtask
  task automatic busy_frames(input int e);
    logic p;
    @(posedge clk_sys);
    p = mst ? fclk_o : fclk;
    n = 0;
    for (k = 0; k < 20000 && busy !== 0; k++) begin
      @(negedge clk_sys);
      if ((mst ? fclk_o : fclk) && !p) n++;
      p = mst ? fclk_o : fclk;
    end
    if (busy !== 0) begin
      bad_count++;
      print_verdict();
    end
    chk("frames to busy low", e[15:0], n[15:0]);
  endtask
  task automatic frames(input int f);
    repeat (f * (dbl ? 128 : 256)) @(negedge clk_sys);
  endtask
  task automatic t_lj_slave();
    data = {24'h400000, 24'hC00000};
    common_voltage_pin = {24'h010000, 24'h020000};
    start(0, 0, 0, 0, 0);
    busy_frames(9);
    frames(8);
    chk("left word", 16'h3F00, hi_w);
    chk("right word", 16'hBE00, lo_w);
  endtask
  task automatic t_master(input logic d, s, input int e);
    start(1, d, s, 0, 0);
    busy_frames(e);
    chk("master oe", 16'h0000, {15'h0, fclk_oe});
  endtask
  task automatic t_i2s_input_cal();
    data = {24'h100000, 24'h000000};
    common_voltage_pin = {24'h300000, 24'h300000};
    start(0, 0, 1, 1, 0);
    busy_frames(9);
    data = {24'h500000, 24'hC00000};
    frames(10);
    chk("i2s left", 16'h2000, lo_w);
    chk("i2s right", 16'h6000, hi_w);
  endtask
  task automatic t_hpf_step();
    data = 0;
    common_voltage_pin = 0;
    start(0, 0, 0, 0, 1);
    busy_frames(9);
    frames(6);
    data = {24'h400000, 24'h000000};
    frames(10);
    chk("filtered step", 16'h0001, {15'h0, hi_w < 16'h4000 && hi_w > 16'h3000});
  endtask
  task automatic t_phase_loss();
    stretch = 1;
    repeat (200) @(negedge clk_sys);
    stretch = 0;
    for (k = 0; k < 1000 && busy !== 1; k++) @(negedge clk_sys);
    chk("busy after phase loss", 16'h0001, {15'h0, busy});
  endtask
  initial begin
    {rst_n, dbl, mst, i2s, zsrc, hpf, valid, stretch, en} = 9'h004;
    data = 0;
    common_voltage_pin = 0;
    bad_count = 0;
    compares = 0;
    t_lj_slave();
    t_master(0, 0, 8);
    t_master(1, 1, 16);
    t_i2s_input_cal();
    t_hpf_step();
    t_phase_loss();
    print_verdict();
  end
endmodule
